// >>> logic/acx_pkg.sv
// Constants and types shared by the configuration-word exchange block.
package acx_pkg;

  // ************************************************************
  // Register numbers and field positions
  // ************************************************************
  localparam logic [4:0]  REG_ADVERTISE    = 5'h04;
  localparam logic [4:0]  REG_PARTNER      = 5'h05;
  localparam int          ACK_BIT          = 14;
  localparam int          SPEED_LSB        = 10;
  localparam logic [1:0]  SPEED_1000       = 2'h2;
  localparam logic [1:0]  STRAP_RXD_MATCH  = 2'h2;
  localparam logic [15:0] ADV_RESET_BASEX  = 16'h0020;
  localparam logic [15:0] ADV_RESET_SGMII  = 16'h9001;
  localparam logic [15:0] ADV_WRITE_MASK   = 16'hbfff;
  localparam logic [15:0] RX_MASK_BASEX    = 16'hf1e0;
  localparam logic [15:0] RX_MASK_SGMII    = 16'h9c00;
  localparam logic [15:0] RESET_WORD       = 16'h0000;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int     CLK_PERIOD_NS       = 50;
  localparam int     LINK_TIMER_BASEX_US = 10000;
  localparam int     LINK_TIMER_SGMII_US = 1600;
  localparam longint WATCHDOG_MS         = 5000;
  localparam int     LINK_BASEX_CYCLES   =
    LINK_TIMER_BASEX_US * 1000 / CLK_PERIOD_NS;
  localparam int     LINK_SGMII_CYCLES   =
    LINK_TIMER_SGMII_US * 1000 / CLK_PERIOD_NS;
  localparam longint WATCHDOG_CYCLES     =
    WATCHDOG_MS * 64'd1000000 / CLK_PERIOD_NS;

  // ************************************************************
  // Negotiation states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_DISABLED_LINK_GOOD = 3'b000,
    ST_ABILITY_DETECT     = 3'b001,
    ST_ACK_DETECT         = 3'b010,
    ST_LINK_GOOD          = 3'b011
  } acx_state_type;

endpackage : acx_pkg

// >>> logic/acx_config_exchange.sv
// Configuration-word exchange, partner status and strap defaults.
//
// Behaviour
// - Base-X received bit 15: partner next-page request
// - Base-X received bit 14: partner acknowledged page
// - Base-X received bits 13:12 show partner remote fault
// - Base-X received bits 8:7 show partner pause ability
// - Base-X bits 6/5: partner half/full duplex
// - Mode bit zero selects SGMII control transfer
// - SGMII: act as receiver or transmitter
// - Hardware sets and detects the acknowledge bit
// - Link-down outside disabled-good and link-good states
// - Link-down clears status bit, squelches clocks
// - SGMII word: D0 one, speed, duplex, ack, link
// - SGMII receiver stores received word automatically
// - SGMII transmitter takes fields from advertise register
// - Five-pin strap selects mode, speed from pins
// - Three-pin strap selects mode, speed 1000
// - Strap default advertises full duplex, link up
// - SGMII received bit 15: partner link status
// - SGMII received bit 12: partner duplex
// - SGMII received bits 11:10: partner speed
// - Non-zero word: ack, store, raise page flags
// - Link timer ends transmission: 10/1.6 ms
// - Start bit with enable begins exchange
// - Watchdog restarts if no link in 5 s
`timescale 1ns/1ps
`default_nettype none

module acx_config_exchange #(
  parameter int unsigned LINK_BASEX_CYCLES = acx_pkg::LINK_BASEX_CYCLES,
  parameter int unsigned LINK_SGMII_CYCLES = acx_pkg::LINK_SGMII_CYCLES,
  parameter int unsigned WATCHDOG_CYCLES   =
    int'(acx_pkg::WATCHDOG_CYCLES)
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        STRAP_COL,
  input  wire logic [1:0]  STRAP_RXD,
  input  wire logic        STRAP_GENERAL_OUTPUT_TWO,
  input  wire logic        STRAP_RX_DV,
  input  wire logic        CFG_WRITE,
  input  wire logic        CFG_BASEX_MODE_SELECT,
  input  wire logic        CFG_NEGOTIATION_ENABLE,
  input  wire logic        NEGOTIATION_START,
  input  wire logic        NEGOTIATION_WATCHDOG_DISABLE,
  input  wire logic        RECOVERED_CLOCK_SQUELCH_ENABLE,
  input  wire logic        LINK_STATUS_READ,
  input  wire logic        PAGE_FLAG_CLEAR,
  input  wire logic        PAGE_IRQ_FLAG_CLEAR,
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic        REG_WRITE,
  input  wire logic [15:0] REG_WDATA,
  output logic      [15:0] REG_RDATA,
  input  wire logic        RX_CONFIG_VALID,
  input  wire logic [15:0] RX_CONFIG_WORD,
  output logic             TX_CONFIG_ACTIVE,
  output logic      [15:0] TX_CONFIG_WORD,
  output logic             BASEX_MODE_SELECT,
  output logic             NEGOTIATION_ENABLE,
  output logic             LINK_DOWN,
  output logic             LINK_STATUS_BIT,
  output logic             CLOCK_SQUELCH,
  output logic             PAGE_RECEIVED_FLAG,
  output logic             PAGE_RECEIVED_IRQ_FLAG
);

  if (LINK_BASEX_CYCLES < 2 || LINK_SGMII_CYCLES < 2 ||
      LINK_BASEX_CYCLES > (1 << 18) || LINK_SGMII_CYCLES > (1 << 18) ||
      WATCHDOG_CYCLES < 2 || WATCHDOG_CYCLES >= (1 << 28))
  begin : gen_bad_timer
    $error("acx_config_exchange: timer count out of range");
  end

  // ************************************************************
  // Strap synchronisers
  // ************************************************************
  // The pins pass two flops that run through reset, so the
  // second stage already holds settled levels at release.
  logic [4:0] strap_meta;
  logic [4:0] strap_sync;
  logic       strap_done;

  always_ff @(posedge CLK)
  begin
    strap_meta <= {STRAP_COL, STRAP_RXD, STRAP_GENERAL_OUTPUT_TWO,
                   STRAP_RX_DV};
    strap_sync <= strap_meta;
  end

  wire       s_col   = strap_sync[4];
  wire [1:0] s_rxd   = strap_sync[3:2];
  wire       s_gpo   = strap_sync[1];
  wire       s_rxdv  = strap_sync[0];
  wire       s_long  = !s_col && s_rxd == acx_pkg::STRAP_RXD_MATCH
                       && s_rxdv;
  wire       s_apply = s_col || s_long;
  wire [1:0] s_speed = s_col ? acx_pkg::SPEED_1000 : s_rxd;
  wire       strap_capture = !strap_done;

  // Default advertise word for the strapped mode.
  wire [15:0] sgmii_default =
    acx_pkg::ADV_RESET_SGMII
    | (16'(s_speed) << acx_pkg::SPEED_LSB);
  wire [15:0] strap_adv = (s_apply && !s_gpo) ? sgmii_default
                          : acx_pkg::ADV_RESET_BASEX;

  // ************************************************************
  // Mode, enable and advertise register
  // ************************************************************
  logic [15:0] advertise_register;
  logic [15:0] partner_receive_register;

  wire wr_adv = REG_WRITE && REG_ADDR == acx_pkg::REG_ADVERTISE;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      strap_done         <= 1'b0;
      BASEX_MODE_SELECT  <= 1'b1;
      NEGOTIATION_ENABLE <= 1'b0;
      advertise_register <= acx_pkg::ADV_RESET_BASEX;
    end
    else
    begin
      strap_done <= 1'b1;
      if (strap_capture)
      begin
        advertise_register <= strap_adv;
        if (s_apply)
        begin
          BASEX_MODE_SELECT  <= s_gpo;
          NEGOTIATION_ENABLE <= 1'b1;
        end
      end
      else
      begin
        if (CFG_WRITE)
        begin
          BASEX_MODE_SELECT  <= CFG_BASEX_MODE_SELECT;
          NEGOTIATION_ENABLE <= CFG_NEGOTIATION_ENABLE;
        end
        if (wr_adv)
          advertise_register <= REG_WDATA & acx_pkg::ADV_WRITE_MASK;
      end
    end
  end

  // ************************************************************
  // Negotiation state machine and timers
  // ************************************************************
  acx_pkg::acx_state_type state;
  acx_pkg::acx_state_type next_state;
  logic [17:0] link_timer;
  logic [27:0] watchdog;
  logic        ack_out;

  wire [17:0] link_limit = BASEX_MODE_SELECT ?
    18'(LINK_BASEX_CYCLES - 1) : 18'(LINK_SGMII_CYCLES - 1);
  wire link_done   = link_timer == link_limit;
  wire wd_done     = watchdog == 28'(WATCHDOG_CYCLES - 1);
  wire word_in     = RX_CONFIG_VALID && RX_CONFIG_WORD != 16'h0000;
  wire start_req   = NEGOTIATION_START && NEGOTIATION_ENABLE;
  wire wd_restart  = wd_done && !NEGOTIATION_WATCHDOG_DISABLE;
  wire partner_ack = partner_receive_register[acx_pkg::ACK_BIT];

  always_comb
  begin
    next_state = state;
    case (state)
      acx_pkg::ST_DISABLED_LINK_GOOD:
        if (NEGOTIATION_ENABLE && strap_done)
          next_state = acx_pkg::ST_ABILITY_DETECT;
      acx_pkg::ST_ABILITY_DETECT:
        if (word_in)
          next_state = acx_pkg::ST_ACK_DETECT;
      acx_pkg::ST_ACK_DETECT:
        if (link_done)
          next_state = partner_ack ? acx_pkg::ST_LINK_GOOD
                       : acx_pkg::ST_ABILITY_DETECT;
      acx_pkg::ST_LINK_GOOD:
        next_state = acx_pkg::ST_LINK_GOOD;
      default:
        next_state = acx_pkg::ST_DISABLED_LINK_GOOD;
    endcase
    if (state != acx_pkg::ST_DISABLED_LINK_GOOD &&
        state != acx_pkg::ST_LINK_GOOD && wd_restart)
      next_state = acx_pkg::ST_ABILITY_DETECT;
    if (start_req)
      next_state = acx_pkg::ST_ABILITY_DETECT;
    if (!NEGOTIATION_ENABLE)
      next_state = acx_pkg::ST_DISABLED_LINK_GOOD;
  end

  wire entering = next_state != state || start_req || wd_restart;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state      <= acx_pkg::ST_DISABLED_LINK_GOOD;
      link_timer <= 18'h00000;
      watchdog   <= 28'h0000000;
    end
    else
    begin
      state      <= next_state;
      link_timer <= (entering || link_done) ? 18'h00000
                    : link_timer + 18'h00001;
      // The watchdog restarts on every new attempt, not on each
      // page, so a partner that never acknowledges is retried.
      if (start_req || wd_restart ||
          state == acx_pkg::ST_DISABLED_LINK_GOOD ||
          state == acx_pkg::ST_LINK_GOOD)
        watchdog <= 28'h0000000;
      else
        watchdog <= watchdog + 28'h0000001;
    end
  end

  // ************************************************************
  // Transmit word, receive capture and page flags
  // ************************************************************
  wire in_exchange = state == acx_pkg::ST_ABILITY_DETECT ||
                     state == acx_pkg::ST_ACK_DETECT;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      ack_out                  <= 1'b0;
      partner_receive_register <= acx_pkg::RESET_WORD;
      PAGE_RECEIVED_FLAG       <= 1'b0;
      PAGE_RECEIVED_IRQ_FLAG   <= 1'b0;
      TX_CONFIG_ACTIVE         <= 1'b0;
      TX_CONFIG_WORD           <= acx_pkg::RESET_WORD;
    end
    else
    begin
      if (next_state == acx_pkg::ST_ABILITY_DETECT && entering)
        ack_out <= 1'b0;
      else if (in_exchange && word_in)
        ack_out <= 1'b1;
      if (in_exchange && word_in)
        partner_receive_register <= RX_CONFIG_WORD;
      // A page arriving with a clear keeps the flag set.
      PAGE_RECEIVED_FLAG <= (in_exchange && word_in)
                            || (PAGE_RECEIVED_FLAG && !PAGE_FLAG_CLEAR);
      PAGE_RECEIVED_IRQ_FLAG <= (in_exchange && word_in)
        || (PAGE_RECEIVED_IRQ_FLAG && !PAGE_IRQ_FLAG_CLEAR);
      TX_CONFIG_ACTIVE <= in_exchange && !link_done;
      // Both modes send the advertise word; only the ack bit is
      // owned by hardware.
      TX_CONFIG_WORD <= {advertise_register[15], ack_out,
                         advertise_register[13:0]};
    end
  end

  // ************************************************************
  // Link-down, status bit and clock squelch
  // ************************************************************
  assign LINK_DOWN = state != acx_pkg::ST_DISABLED_LINK_GOOD &&
                     state != acx_pkg::ST_LINK_GOOD;
  assign CLOCK_SQUELCH = LINK_DOWN &&
                         RECOVERED_CLOCK_SQUELCH_ENABLE;

  // Latched low: a drop stays visible until software reads it.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      LINK_STATUS_BIT <= 1'b0;
    else if (LINK_DOWN)
      LINK_STATUS_BIT <= 1'b0;
    else if (LINK_STATUS_READ)
      LINK_STATUS_BIT <= 1'b1;
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  wire [15:0] rx_view = partner_receive_register &
    (BASEX_MODE_SELECT ? acx_pkg::RX_MASK_BASEX
                       : acx_pkg::RX_MASK_SGMII);
  wire [15:0] rd_mux =
    (REG_ADDR == acx_pkg::REG_ADVERTISE) ? advertise_register :
    (REG_ADDR == acx_pkg::REG_PARTNER)   ? rx_view : 16'h0000;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      REG_RDATA <= 16'h0000;
    else
      REG_RDATA <= rd_mux;
  end

endmodule : acx_config_exchange

`default_nettype wire

// >>> verification/acx_config_exchange_asserts.sv
// Concurrent checks on the exchange block's ports.
`timescale 1ns/1ps
`default_nettype none
module acx_config_exchange_asserts (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [4:0]  REG_ADDR,
  input wire logic [15:0] REG_RDATA,
  input wire logic        RX_CONFIG_VALID,
  input wire logic [15:0] RX_CONFIG_WORD,
  input wire logic        TX_CONFIG_ACTIVE,
  input wire logic [15:0] TX_CONFIG_WORD,
  input wire logic        BASEX_MODE_SELECT,
  input wire logic        NEGOTIATION_ENABLE,
  input wire logic        RECOVERED_CLOCK_SQUELCH_ENABLE,
  input wire logic        LINK_DOWN,
  input wire logic        LINK_STATUS_BIT,
  input wire logic        CLOCK_SQUELCH,
  input wire logic        PAGE_RECEIVED_FLAG
);
  // ********************************************************
  // Properties
  // ********************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // A word only counts while an exchange is running.
  wire logic page_in = RX_CONFIG_VALID && (RX_CONFIG_WORD != 16'h0000) &&
    LINK_DOWN && NEGOTIATION_ENABLE;
  chk_squelch_follows: assert property (
    CLOCK_SQUELCH == (LINK_DOWN && RECOVERED_CLOCK_SQUELCH_ENABLE))
    else $error("squelch mismatch");
  chk_status_cleared: assert property (
    LINK_DOWN |=> !LINK_STATUS_BIT) else $error("status bit not cleared");
  chk_page_flag: assert property (
    page_in |=> PAGE_RECEIVED_FLAG) else $error("page flag missing");
  chk_ack_sent: assert property (
    $rose(PAGE_RECEIVED_FLAG) && TX_CONFIG_ACTIVE |=>
    TX_CONFIG_WORD[acx_pkg::ACK_BIT]) else $error("ack not sent");
  chk_start_unacked: assert property (
    $rose(TX_CONFIG_ACTIVE) |-> !TX_CONFIG_WORD[acx_pkg::ACK_BIT])
    else $error("exchange opened with ack");
  chk_sgmii_rx_mask: assert property (
    REG_ADDR == acx_pkg::REG_PARTNER && !BASEX_MODE_SELECT &&
    !$past(BASEX_MODE_SELECT) |=>
    (REG_RDATA & ~acx_pkg::RX_MASK_SGMII) == 16'h0000) else $error("sgmii rx");
  chk_basex_rx_mask: assert property (
    REG_ADDR == acx_pkg::REG_PARTNER && BASEX_MODE_SELECT &&
    $past(BASEX_MODE_SELECT) |=>
    (REG_RDATA & ~acx_pkg::RX_MASK_BASEX) == 16'h0000) else $error("basex rx");
  chk_adv_reserved: assert property (
    REG_ADDR == acx_pkg::REG_ADVERTISE |=> !REG_RDATA[acx_pkg::ACK_BIT])
    else $error("advertise bit 14 set");
  chk_disabled_link: assert property (
    !NEGOTIATION_ENABLE [*2] |-> !LINK_DOWN) else $error("link-down while off");
  cover property ($fell(LINK_DOWN));
  cover property ($rose(PAGE_RECEIVED_FLAG));
  cover property (CLOCK_SQUELCH);
endmodule : acx_config_exchange_asserts
bind acx_config_exchange acx_config_exchange_asserts
  acx_config_exchange_asserts_i (.CLK, .RST_N, .REG_ADDR, .REG_RDATA,
  .RX_CONFIG_VALID, .RX_CONFIG_WORD, .TX_CONFIG_ACTIVE, .TX_CONFIG_WORD,
  .BASEX_MODE_SELECT, .NEGOTIATION_ENABLE, .RECOVERED_CLOCK_SQUELCH_ENABLE,
  .LINK_DOWN, .LINK_STATUS_BIT, .CLOCK_SQUELCH, .PAGE_RECEIVED_FLAG);
`default_nettype wire

// >>> verification/acx_link_peer.sv
// Behavioural link partner answering the block's configuration words.
`timescale 1ns/1ps
`default_nettype none
module acx_link_peer (
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic [15:0] page,
  input  wire logic        tx_active,
  input  wire logic [15:0] tx_word,
  output logic             rx_valid,
  output logic      [15:0] rx_word
);
  // ********************************************************
  // Acknowledge tracking
  // ********************************************************
  logic acked;
  // Acknowledge only once a non-zero word was seen; drop it when sending ends.
  always_ff @(posedge clk)
    acked <= tx_active && (acked || tx_word != 16'h0000);
  assign rx_valid = en;
  // An idle word line shows the inverse of the page, never a stale copy.
  assign rx_word = en ? (page | {1'b0, acked, 14'h0000}) : ~page;
endmodule : acx_link_peer
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the configuration-word exchange block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        CLK, RST_N, STRAP_COL, STRAP_GENERAL_OUTPUT_TWO, STRAP_RX_DV;
  logic        CFG_WRITE, CFG_BASEX_MODE_SELECT, CFG_NEGOTIATION_ENABLE;
  logic        NEGOTIATION_START, NEGOTIATION_WATCHDOG_DISABLE;
  logic        RECOVERED_CLOCK_SQUELCH_ENABLE, LINK_STATUS_READ, peer_en;
  logic        PAGE_FLAG_CLEAR, PAGE_IRQ_FLAG_CLEAR, REG_WRITE, RX_CONFIG_VALID;
  logic        TX_CONFIG_ACTIVE, BASEX_MODE_SELECT, NEGOTIATION_ENABLE;
  logic        LINK_DOWN, LINK_STATUS_BIT, CLOCK_SQUELCH, PAGE_RECEIVED_FLAG;
  logic        PAGE_RECEIVED_IRQ_FLAG;
  logic [1:0]  STRAP_RXD;
  logic [4:0]  REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA, RX_CONFIG_WORD, TX_CONFIG_WORD, peer_page;
  int          fails = 0, n_tests = 0, cycles = 0;
  // Strap pins, then expected mode and enable, then advertise default.
  localparam logic [22:0] STRAPS [4] =
    '{23'h419801, 23'h259801, 23'h2f0020, 23'h360020};
  acx_config_exchange #(.LINK_BASEX_CYCLES(40), .LINK_SGMII_CYCLES(20),
    .WATCHDOG_CYCLES(400)) acx_config_exchange_i (.CLK, .RST_N, .STRAP_COL,
    .STRAP_RXD, .STRAP_GENERAL_OUTPUT_TWO, .STRAP_RX_DV, .CFG_WRITE,
    .CFG_BASEX_MODE_SELECT, .CFG_NEGOTIATION_ENABLE, .NEGOTIATION_START,
    .NEGOTIATION_WATCHDOG_DISABLE, .RECOVERED_CLOCK_SQUELCH_ENABLE,
    .LINK_STATUS_READ, .PAGE_FLAG_CLEAR, .PAGE_IRQ_FLAG_CLEAR, .REG_ADDR,
    .REG_WRITE, .REG_WDATA, .REG_RDATA, .RX_CONFIG_VALID, .RX_CONFIG_WORD,
    .TX_CONFIG_ACTIVE, .TX_CONFIG_WORD, .BASEX_MODE_SELECT, .NEGOTIATION_ENABLE,
    .LINK_DOWN, .LINK_STATUS_BIT, .CLOCK_SQUELCH, .PAGE_RECEIVED_FLAG,
    .PAGE_RECEIVED_IRQ_FLAG);
  acx_link_peer acx_link_peer_i (.clk(CLK), .en(peer_en), .page(peer_page),
    .tx_active(TX_CONFIG_ACTIVE), .tx_word(TX_CONFIG_WORD),
    .rx_valid(RX_CONFIG_VALID), .rx_word(RX_CONFIG_WORD));
  // ********************************************************
  // Clock, timeout and helpers
  // ********************************************************
  always #25 CLK = ~CLK;
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      print_verdict();
    end
  end
  task automatic step();
    @(posedge CLK);
    #1;
  endtask : step
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    {REG_ADDR, REG_WDATA, REG_WRITE} = {a, d, 1'b1};
    step();
    REG_WRITE = 0;
  endtask : reg_wr
  task automatic reg_rd(input logic [4:0] a, input logic [15:0] exp);
    REG_ADDR = a;
    step();
    check(REG_RDATA, exp);
  endtask : reg_rd
  // One full exchange; a read-only write is slipped in, though the received page overwrites that register before the read.
  task automatic exchange(input logic basex, input logic [15:0] adv, page, rd);
    {CFG_BASEX_MODE_SELECT, CFG_NEGOTIATION_ENABLE, CFG_WRITE} = {basex, 2'b11};
    step();
    CFG_WRITE = 0;
    reg_wr(5'h04, adv);
    reg_wr(5'h05, 16'hffff);
    {PAGE_FLAG_CLEAR, PAGE_IRQ_FLAG_CLEAR, NEGOTIATION_START} = 3'b111;
    step();
    {PAGE_FLAG_CLEAR, PAGE_IRQ_FLAG_CLEAR, NEGOTIATION_START} = 3'b000;
    for (int i = 0; i < 20 && TX_CONFIG_ACTIVE !== 1'b1; i++) step();
    check(TX_CONFIG_WORD, adv & 16'hbfff);
    check({PAGE_RECEIVED_FLAG, PAGE_RECEIVED_IRQ_FLAG}, 2'b00);
    check({LINK_DOWN, LINK_STATUS_BIT, CLOCK_SQUELCH}, 3'b101);
    {peer_page, peer_en} = {page, 1'b1};
    for (int i = 0; i < 20 && PAGE_RECEIVED_FLAG !== 1'b1; i++) step();
    check({PAGE_RECEIVED_FLAG, PAGE_RECEIVED_IRQ_FLAG}, 2'b11);
    step();
    check(TX_CONFIG_WORD[14], 1'b1);
    for (int i = 0; i < 100 && LINK_DOWN !== 1'b0; i++) step();
    step();
    check({LINK_DOWN, TX_CONFIG_ACTIVE, CLOCK_SQUELCH}, 3'b000);
    LINK_STATUS_READ = 1;
    step();
    LINK_STATUS_READ = 0;
    check(LINK_STATUS_BIT, 1'b1);
    reg_rd(5'h05, rd);
    peer_en = 0;
  endtask : exchange
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // ********************************************************
  // Main sequence
  // ********************************************************
  initial
  begin
    {CLK, RST_N, CFG_WRITE, CFG_BASEX_MODE_SELECT, CFG_NEGOTIATION_ENABLE} = '0;
    {NEGOTIATION_START, NEGOTIATION_WATCHDOG_DISABLE, LINK_STATUS_READ} = '0;
    {PAGE_FLAG_CLEAR, PAGE_IRQ_FLAG_CLEAR, REG_WRITE, peer_en} = '0;
    {REG_ADDR, REG_WDATA, peer_page} = '0;
    RECOVERED_CLOCK_SQUELCH_ENABLE = 1;
    foreach (STRAPS[k])
    begin
      {STRAP_COL, STRAP_RXD, STRAP_GENERAL_OUTPUT_TWO, STRAP_RX_DV} =
        STRAPS[k][22:18];
      RST_N = 0;
      repeat (4) step();
      RST_N = 1;
      repeat (2) step();
      check({BASEX_MODE_SELECT, NEGOTIATION_ENABLE}, STRAPS[k][17:16]);
      reg_rd(5'h04, STRAPS[k][15:0]);
    end
    reg_rd(5'h1f, 16'h0000);
    exchange(0, 16'hd401, 16'h9401, 16'h9400);
    exchange(1, 16'h01a0, 16'ha1e0, 16'he1e0);
    exchange(0, 16'h0001, 16'h8801, 16'h8800);
    // A page arrives ten cycles before the 400-cycle watchdog runs out:
    // with the watchdog on, the restart withdraws the acknowledge.
    for (int w = 0; w < 2; w++)
    begin
      NEGOTIATION_WATCHDOG_DISABLE = w[0];
      RECOVERED_CLOCK_SQUELCH_ENABLE = w[0];
      {PAGE_FLAG_CLEAR, PAGE_IRQ_FLAG_CLEAR, NEGOTIATION_START} = 3'b111;
      step();
      {PAGE_FLAG_CLEAR, PAGE_IRQ_FLAG_CLEAR, NEGOTIATION_START} = 3'b000;
      repeat (390) step();
      peer_en = 1;
      repeat (11) step();
      check(TX_CONFIG_WORD[14], w[0]);
      check({LINK_DOWN, CLOCK_SQUELCH}, {1'b1, w[0]});
      peer_en = 0;
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
